/* core/txli_pkg.sv */
// Package of constants, types and carriers for the transmit line input block
package txli_pkg;

  // ****************************************
  // Line rate modes
  // ****************************************
  typedef enum logic [1:0] {
    TXLI_RATE_E3,
    TXLI_RATE_DS3,
    TXLI_RATE_STS1
  } txli_rate_e;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic TXLI_RST_BIT = 1'b0;           // Data bits after reset
  localparam logic [1:0] TXLI_RST_CNT = 2'h0;     // Buffer fill after reset
  localparam int TXLI_BUF_DEPTH = 2;              // Skid buffer entries
  localparam logic [1:0] TXLI_BUF_FULL = 2'h2;    // Fill count when full

  // ****************************************
  // Carriers
  // ****************************************
  // One sampled line symbol, both rails
  typedef struct packed {
    logic pos;
    logic neg;
  } txli_sym_s;

  // Static configuration straps
  typedef struct packed {
    logic host_mode;          // High in host mode
    logic tx_edge_invert_sel; // Edge select pin (serial clock in host mode)
    logic host_rising_edge;   // Channel control bit, host mode edge
    logic rail_mode_sel;      // High single rail (hardware mode)
    logic host_single_rail;   // Block control bit, host mode rail
    logic line_buildout_disable_sel;
    txli_rate_e rate;
  } txli_cfg_s;

  // Tri-state pin pair for one line output
  typedef struct packed {
    logic o;
    logic oe;
  } txli_pin_s;

endpackage

/* core/txli_top.sv */
// Transmit line input interface: sampling, buffering and line pair drive
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Transmitter enabled while transmitter-on is high
// - Transmitter-on still rules outputs in host mode
// - Transmitter off puts tip and ring high-Z
// - Sample both rails on one selected edge
// - Hardware mode, select high: rising edge
// - Host mode: select pin is serial clock
// - Dual rail: negative rail sampled too
// - Single rail: negative input ignored
// - Build-out select high disables shaping stage
// - Build-out select only acts in DS3/STS-1
// - Host mode ignores build-out select pin
// - Tip and ring form complementary bipolar pair
// - Hardware mode, rail select high single, low dual
module txli_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic tx_line_clock_in,
  input wire logic tx_pos_rail_in,
  input wire logic tx_neg_rail_in,
  input wire logic transmitter_on_in,
  input wire txli_pkg::txli_cfg_s CFG,
  input wire logic SHAPE_READY,
  output var txli_pkg::txli_pin_s line_out_tip,
  output var txli_pkg::txli_pin_s line_out_ring,
  output logic SHAPE_VALID,
  output logic BUILDOUT_EN,
  output logic SINGLE_RAIL,
  output logic OVERRUN
);
  import txli_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] clk_s;     // Clock synchroniser, [0] first stage
    logic clk_prev;        // Last synchronised clock level
    logic [1:0] pos_s;     // Positive rail synchroniser
    logic [1:0] neg_s;     // Negative rail synchroniser
    logic [1:0] on_s;      // Transmitter-on synchroniser
    txli_sym_s [1:0] buf_mem; // Two-entry buffer
    logic rd_ptr;          // Buffer read pointer
    logic wr_ptr;          // Buffer write pointer
    logic [1:0] cnt;       // Entries held
    txli_sym_s line_sym;   // Symbol on the line now
    logic tx_en;           // Synchronised transmitter enable
    logic ovr;             // Sticky overrun flag
  } txli_st_s;

  txli_st_s st_q; // Registered state
  txli_st_s st_d; // Next state

  // Combinational helpers
  logic clk_rise;
  logic clk_fall;
  logic take_edge;
  logic rising_sel;
  logic single_rail;
  txli_sym_s samp;
  logic push;
  logic pop;
  txli_sym_s head;

  // ****************************************
  // Edge and mode decode
  // ****************************************
  always_comb begin
    clk_rise = st_q.clk_s[1] & ~st_q.clk_prev;
    clk_fall = ~st_q.clk_s[1] & st_q.clk_prev;
    // Host mode uses the control bit; the pin is serial clock there
    rising_sel = CFG.host_mode ? CFG.host_rising_edge : CFG.tx_edge_invert_sel;
    // Select high picks rising, low picks falling
    take_edge = rising_sel ? clk_rise : clk_fall;
    single_rail = CFG.host_mode ? CFG.host_single_rail : CFG.rail_mode_sel;
    samp.pos = st_q.pos_s[1];
    // Negative rail forced low in single rail so a floating pin is harmless
    samp.neg = single_rail ? 1'b0 : st_q.neg_s[1];
    head = st_q.buf_mem[st_q.rd_ptr];
    push = take_edge && (st_q.cnt != TXLI_BUF_FULL);
    pop = (st_q.cnt != TXLI_RST_CNT) && SHAPE_READY;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.clk_s = {st_q.clk_s[0], tx_line_clock_in};
    st_d.clk_prev = st_q.clk_s[1];
    st_d.pos_s = {st_q.pos_s[0], tx_pos_rail_in};
    st_d.neg_s = {st_q.neg_s[0], tx_neg_rail_in};
    st_d.on_s = {st_q.on_s[0], transmitter_on_in};
    st_d.tx_en = st_q.on_s[1];
    // Store a sampled symbol when there is room
    if (push) begin
      st_d.buf_mem[st_q.wr_ptr] = samp;
      st_d.wr_ptr = ~st_q.wr_ptr;
    end
    // Hand the oldest symbol to the line
    if (pop) begin
      st_d.line_sym = head;
      st_d.rd_ptr = ~st_q.rd_ptr;
    end
    st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
    // A full buffer means the shaper stalled too long; flag it sticky
    if (take_edge && !push) begin
      st_d.ovr = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q <= '0;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    // Positive mark drives tip high, negative mark drives ring high
    line_out_tip.o = st_q.line_sym.pos & ~st_q.line_sym.neg;
    line_out_ring.o = st_q.line_sym.neg & ~st_q.line_sym.pos;
    // Output enable follows transmitter-on in either mode
    line_out_tip.oe = st_q.tx_en;
    line_out_ring.oe = st_q.tx_en;
    SHAPE_VALID = st_q.cnt != TXLI_RST_CNT;
    // Build-out pin only acts in DS3/STS-1 hardware mode; E3 and host mode hold it on
    BUILDOUT_EN = CFG.host_mode || (CFG.rate == TXLI_RATE_E3) ||
      !CFG.line_buildout_disable_sel;
    SINGLE_RAIL = single_rail;
    OVERRUN = st_q.ovr;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence rise_seen_s;
    CE && clk_rise && !CFG.host_mode && CFG.tx_edge_invert_sel && st_q.cnt == 2'h0;
  endsequence

  // Oldest symbol leaves the buffer as a positive mark
  sequence pop_mark_s;
    CE && pop && head.pos && !head.neg;
  endsequence

  // Oldest symbol leaves the buffer as a space
  sequence pop_space_s;
    CE && pop && !head.pos && !head.neg;
  endsequence

  tip_tristate_a: assert property (CE && !st_q.on_s[1] |=> !line_out_tip.oe)
    else $error("tip driven while transmitter off");
  ring_tristate_a: assert property (!line_out_tip.oe |-> !line_out_ring.oe)
    else $error("ring driven while tip released");
  on_follow_a: assert property (CE && st_q.on_s[1] |=> line_out_tip.oe)
    else $error("transmitter not enabled");
  host_on_a: assert property (CE && CFG.host_mode && st_q.on_s[1] |=> line_out_ring.oe)
    else $error("host mode ignores transmitter-on");
  rise_take_a: assert property (rise_seen_s |=> st_q.cnt == 2'h1)
    else $error("rising edge not sampled");
  fall_take_a: assert property (CE && clk_fall && !CFG.host_mode && !CFG.tx_edge_invert_sel
    && st_q.cnt == 2'h0 |=> st_q.cnt == 2'h1)
    else $error("falling edge not sampled");
  host_pin_a: assert property (CFG.host_mode |-> rising_sel == CFG.host_rising_edge)
    else $error("select pin used in host mode");
  single_neg_a: assert property (single_rail |-> !samp.neg)
    else $error("negative rail used in single rail");
  e3_buildout_a: assert property (CFG.rate == TXLI_RATE_E3 |-> BUILDOUT_EN)
    else $error("build-out select acted in E3");
  bipolar_a: assert property (!(line_out_tip.o && line_out_ring.o))
    else $error("tip and ring both marked");
  rail_sel_a: assert property (!CFG.host_mode |-> SINGLE_RAIL == CFG.rail_mode_sel)
    else $error("rail mode select wrong");

  // Line pair must show each popped mark or space one cycle later; a symbol with both rails high is not checked
  pos_mark_a: assert property (pop_mark_s |=> line_out_tip.o && !line_out_ring.o)
    else $error("positive mark not on tip");
  line_space_a: assert property (pop_space_s |=> !line_out_tip.o && !line_out_ring.o)
    else $error("space not idle on line");
  neg_mark_a: assert property (CE && pop && head.neg && !head.pos
    |=> line_out_ring.o && !line_out_tip.o)
    else $error("negative mark not on ring");

  // Ring follows transmitter-on on its own, not only through tip
  off_ring_a: assert property (CE && !st_q.on_s[1] |=> !line_out_ring.oe)
    else $error("ring driven while transmitter off");

  // Dual rail passes the synchronised negative rail untouched
  dual_neg_a: assert property (!single_rail |-> samp.neg == st_q.neg_s[1])
    else $error("negative rail lost in dual rail");

  // A selected edge with room always lands in the buffer
  edge_store_a: assert property (CE && take_edge && st_q.cnt != TXLI_BUF_FULL
    |=> st_q.cnt != TXLI_RST_CNT)
    else $error("selected edge not stored");

  // Build-out pin acts in hardware mode at DS3 and STS-1 rates
  buildout_pin_a: assert property (!CFG.host_mode && CFG.rate != TXLI_RATE_E3
    |-> BUILDOUT_EN == !CFG.line_buildout_disable_sel)
    else $error("build-out pin not obeyed");
  // Host mode must not depend on the pin, so the stage stays on
  host_buildout_a: assert property (CFG.host_mode |-> BUILDOUT_EN)
    else $error("build-out pin used in host mode");

  // Overrun is sticky until reset; a lost edge must raise it
  ovr_set_a: assert property (CE && take_edge && st_q.cnt == TXLI_BUF_FULL |=> OVERRUN)
    else $error("lost edge did not flag overrun");
  ovr_hold_a: assert property (OVERRUN |=> OVERRUN)
    else $error("overrun cleared without reset");

endmodule
`default_nettype wire

/* verif/txli_framer.sv */
// Framer model: line clock that runs while run is high, with random rails
`timescale 1ns/1ps
`default_nettype none
module txli_framer (
  input wire logic run,
  input wire logic rise,
  output logic lclk,
  output logic pos,
  output logic neg
);
  integer seed = 32'h6067aa02; // Fixed seed for repeatable rails
  // 200 ns clock; it parks low only, so no false edge shows after reset
  initial begin
    {lclk, pos, neg} = 3'h0;
    forever begin
      #100;
      if (run || lclk) begin
        lclk = ~lclk;
        // Rails move on the unsampled edge; neg kept noisy on purpose
        if (lclk !== rise) begin
          {pos, neg} = 2'($random(seed));
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the transmit line input block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import txli_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ready = 1'b0, ton = 1'b1, run = 1'b0, pend = 1'b0;
  logic lclk, pos, neg, bo_en, single, ovr, vld;
  txli_cfg_s cfg = '0;
  txli_pin_s tip, ring;
  logic [1:0] exp_q[$]; // Expected tip/ring pairs, oldest first
  int num_errors = 0, n_tests = 0;
  integer seed = 32'h6067aa02;
  wire logic rise = cfg.host_mode ? cfg.host_rising_edge : cfg.tx_edge_invert_sel;
  wire logic sgl = cfg.host_mode ? cfg.host_single_rail : cfg.rail_mode_sel;
  wire logic n = neg & ~sgl;
  initial forever #12.5 clk = ~clk;
  txli_top DUT (.SYS_CLK(clk), .RST(rst), .CE(1'b1), .tx_line_clock_in(lclk),
    .tx_pos_rail_in(pos), .tx_neg_rail_in(neg), .transmitter_on_in(ton), .CFG(cfg),
    .SHAPE_READY(ready), .line_out_tip(tip), .line_out_ring(ring), .SHAPE_VALID(vld),
    .BUILDOUT_EN(bo_en), .SINGLE_RAIL(single), .OVERRUN(ovr));
  txli_framer FRM (.run(run), .rise(rise), .lclk(lclk), .pos(pos), .neg(neg));
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait until every noted symbol has left the line
  task automatic drain();
    int i;
    for (i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) begin
      num_errors++;
      finish_test();
    end
  endtask
  // Note the symbol at each selected link edge
  always @(lclk) if (lclk === rise && $time > 0) exp_q.push_back({pos & ~n, n & ~pos});
  // Pop seen at a negedge shows on tip/ring one negedge later
  always @(negedge clk) begin
    if (pend) chk({tip.o, ring.o}, exp_q.pop_front());
    pend = vld & ready & ~rst;
  end
  initial begin
    // Straps: hw rise dual, hw fall single, host rise single, host fall dual
    for (int k = 0; k < 4; k++) begin
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      cfg <= '{k[1], k[0] ~^ k[1], ~k[0], k[0], k[0] ^ k[1], 1'b0, TXLI_RATE_DS3};
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      run = 1'b1;
      repeat (160) begin
        @(posedge clk);
        ready <= 1'($random(seed));
      end
      run = 1'b0;
      ready <= 1'b1;
      drain();
      chk({single, ovr}, {k[0] ^ k[1], 1'b0});
    end
    // Receiver stalls: third edge finds the buffer full
    ready <= 1'b0;
    run = 1'b1;
    repeat (40) @(posedge clk);
    run = 1'b0;
    chk({1'b0, ovr}, 2'h1);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    exp_q.delete();
    rst <= 1'b0;
    // Every rate, build-out pin and mode, with the transmitter toggling
    for (int r = 0; r < 12; r++) begin
      cfg <= '{r > 5, 1'b0, 1'b0, 1'b0, 1'b0, 1'((r / 3) % 2), txli_rate_e'(r % 3)};
      ton <= r[0];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({bo_en, 1'b0}, {(r > 5) | (r % 3 == 0) | ((r / 3) % 2 == 0), 1'b0});
      chk({tip.oe, ring.oe}, {2{r[0]}});
    end
    finish_test();
  end
endmodule
`default_nettype wire
